/* File: rtl/iackbt_defs.svh */
// Notes on behaviour
// (RULE1) error ending an autovectored acknowledge cycle takes the spurious interrupt exception; code raises sticky fatal fault if autovector was seen
// (RULE2) outside logic must not raise bus error after autovector in an acknowledge cycle
// (RULE3) autovector and size acknowledge together: size acknowledge wins
// (RULE4) top level line dropped then reasserted before acknowledge gives one interrupt
// (RULE5) cycle ended by external size acknowledge lasts at least three clocks
// (RULE6) outside logic should end its cycle on strobe rising edge, not counted clocks
// (RULE7) outside size acknowledge timed for two or more waits ends cycles correctly
// (RULE8) autovector ending makes the vector internally from the acknowledged level
`ifndef IACKBT_DEFS_SVH
`define IACKBT_DEFS_SVH
`define IACKBT_MIN_CYCLE_CLOCKS 3'h3
`define IACKBT_AUTOVEC_BASE     8'h18
`define IACKBT_SPURIOUS_VECTOR  8'h18
`define IACKBT_TOP_LEVEL        3'h7
`endif

/* File: rtl/iackbt_pkg.sv */
package iackbt_pkg;
	typedef enum logic [1:0] {
		IACKBT_END_NONE,
		IACKBT_END_DATA,
		IACKBT_END_AUTOVEC,
		IACKBT_END_ERROR
	} iackbt_end_e;
endpackage

/* File: rtl/iackbt_sync.sv */
`timescale 1ns/1ns
`default_nettype none
// three-stage pin synchroniser, change accepted when stages two and three agree
module iackbt_sync (
	input  wire logic clock_in,
	input  wire logic reset_in,
	input  wire logic pin_in,
	output logic      level_out
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;

	// first stage feeds only the second
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
		end else begin
			s1_reg <= pin_in;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
		end
	end

	// filtered level holds until two stages agree
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			level_out <= 1'b0;
		end else if (s2_reg == s3_reg) begin
			level_out <= s3_reg;
		end
	end
endmodule
`default_nettype wire

/* File: rtl/iackbt_top.sv */
`timescale 1ns/1ns
`default_nettype none
`include "iackbt_defs.svh"
module iackbt_top (
	input  wire logic                 clock_in,
	input  wire logic                 reset_in,
	input  wire logic                 cycle_start_in,
	input  wire logic                 cycle_is_interrupt_ack_cycle_in,
	input  wire logic [2:0]           interrupt_ack_cycle_level_in,
	input  wire logic                 data_size_ack_n_in,
	input  wire logic                 autovector_request_n_in,
	input  wire logic                 bus_error_input_n_in,
	input  wire logic                 highest_level_int_line_n_in,
	input  wire logic [7:0]           data_bus_in,
	output logic                      address_strobe_n_out,
	output logic                      data_strobe_pin_n_out,
	output logic                      interrupt_ack_cycle_out,
	output logic                      cycle_done_out,
	output iackbt_pkg::iackbt_end_e   end_kind_out,
	output logic [7:0]                vector_out,
	output logic                      vector_valid_out,
	output logic                      spurious_exc_out,
	output logic                      fatal_fault_out,
	output logic                      top_int_request_out
);
	import iackbt_pkg::*;

	typedef enum logic [1:0] {IACKBT_IDLE, IACKBT_ACTIVE, IACKBT_END} iackbt_state_e;

	logic          data_size_ack_lvl;
	logic          autovector_request_lvl;
	logic          bus_error_input_lvl;
	logic          highest_level_int_line_lvl;
	iackbt_state_e state_reg;
	logic [2:0]    clocks_reg;
	logic          autovector_request_seen_reg;
	logic          highest_level_int_line_prev_reg;
	logic          highest_level_int_line_pend_reg;
	logic          is_interrupt_ack_cycle_reg;
	logic [2:0]    level_reg;
	logic          min_met;

	// active-low pins, synchronised; inverted so one means asserted
	iackbt_sync u_sync_data_size_ack (.clock_in(clock_in), .reset_in(reset_in),
		.pin_in(~data_size_ack_n_in), .level_out(data_size_ack_lvl));
	iackbt_sync u_sync_autovector_request (.clock_in(clock_in), .reset_in(reset_in),
		.pin_in(~autovector_request_n_in), .level_out(autovector_request_lvl));
	iackbt_sync u_sync_bus_error_input (.clock_in(clock_in), .reset_in(reset_in),
		.pin_in(~bus_error_input_n_in), .level_out(bus_error_input_lvl));
	iackbt_sync u_sync_highest_level_int_line (.clock_in(clock_in), .reset_in(reset_in),
		.pin_in(~highest_level_int_line_n_in), .level_out(highest_level_int_line_lvl));

	// termination only counts once the cycle has run its minimum clocks
	assign min_met = (clocks_reg >= (`IACKBT_MIN_CYCLE_CLOCKS - 3'h1)); // RULE5

	// cycle sequencer and strobes
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			state_reg             <= IACKBT_IDLE;
			clocks_reg            <= 3'h0;
			is_interrupt_ack_cycle_reg           <= 1'b0;
			level_reg             <= 3'h0;
			address_strobe_n_out  <= 1'b1;
			data_strobe_pin_n_out <= 1'b1;
			interrupt_ack_cycle_out <= 1'b0;
		end else begin
			case (state_reg)
				IACKBT_IDLE: begin
					clocks_reg <= 3'h0;
					if (cycle_start_in) begin
						state_reg             <= IACKBT_ACTIVE;
						is_interrupt_ack_cycle_reg           <= cycle_is_interrupt_ack_cycle_in;
						level_reg             <= interrupt_ack_cycle_level_in;
						address_strobe_n_out  <= 1'b0;
						data_strobe_pin_n_out <= 1'b0;
						interrupt_ack_cycle_out <= cycle_is_interrupt_ack_cycle_in;
					end
				end
				IACKBT_ACTIVE: begin
					if (clocks_reg != 3'h7) begin
						clocks_reg <= clocks_reg + 3'h1;
					end
					// strobes rise on termination so outside logic can key on the edge
					if (min_met && (data_size_ack_lvl || bus_error_input_lvl || (autovector_request_lvl && is_interrupt_ack_cycle_reg))) begin
						state_reg             <= IACKBT_END; // RULE5
						address_strobe_n_out  <= 1'b1;
						data_strobe_pin_n_out <= 1'b1;
					end
				end
				IACKBT_END: begin
					// wait for outside acknowledges to release before a new cycle
					if (!data_size_ack_lvl && !autovector_request_lvl && !bus_error_input_lvl) begin
						state_reg             <= IACKBT_IDLE;
						interrupt_ack_cycle_out <= 1'b0;
					end
				end
				default: state_reg <= IACKBT_IDLE;
			endcase
		end
	end

	// remember autovector seen in this acknowledge cycle, to spot a late error
	always_ff @(posedge clock_in) begin
		if (reset_in || state_reg == IACKBT_IDLE) begin
			autovector_request_seen_reg <= 1'b0;
		end else if (state_reg == IACKBT_ACTIVE && is_interrupt_ack_cycle_reg && autovector_request_lvl) begin
			autovector_request_seen_reg <= 1'b1;
		end
	end

	// termination priority: size ack over error over autovector
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			cycle_done_out   <= 1'b0;
			end_kind_out     <= IACKBT_END_NONE;
			vector_out       <= 8'h00;
			vector_valid_out <= 1'b0;
			spurious_exc_out <= 1'b0;
			fatal_fault_out  <= 1'b0;
		end else begin
			cycle_done_out   <= 1'b0;
			vector_valid_out <= 1'b0;
			spurious_exc_out <= 1'b0;
			if (state_reg == IACKBT_ACTIVE && min_met) begin
				if (data_size_ack_lvl) begin
					cycle_done_out <= 1'b1;
					end_kind_out   <= IACKBT_END_DATA; // RULE3
					if (is_interrupt_ack_cycle_reg) begin
						vector_out       <= data_bus_in; // RULE3
						vector_valid_out <= 1'b1;
					end
				end else if (bus_error_input_lvl && is_interrupt_ack_cycle_reg && autovector_request_seen_reg) begin
					// error after autovector: unrecoverable, sticky until reset
					cycle_done_out  <= 1'b1;
					end_kind_out    <= IACKBT_END_ERROR;
					fatal_fault_out <= 1'b1; // RULE2
				end else if (bus_error_input_lvl) begin
					cycle_done_out <= 1'b1;
					end_kind_out   <= IACKBT_END_ERROR;
					if (is_interrupt_ack_cycle_reg) begin
						spurious_exc_out <= 1'b1; // RULE1
						vector_out       <= `IACKBT_SPURIOUS_VECTOR; // RULE1
						vector_valid_out <= 1'b1;
					end
				end else if (autovector_request_lvl && is_interrupt_ack_cycle_reg) begin
					cycle_done_out   <= 1'b1;
					end_kind_out     <= IACKBT_END_AUTOVEC;
					vector_out       <= `IACKBT_AUTOVEC_BASE + {5'h00, level_reg}; // RULE8
					vector_valid_out <= 1'b1;
				end
			end
		end
	end

	// top-level line is edge sensitive; a pending request clears only on its acknowledge,
	// so a release and reassert before that acknowledge still yields one interrupt
	always_ff @(posedge clock_in) begin
		if (reset_in) begin
			highest_level_int_line_prev_reg       <= 1'b0;
			highest_level_int_line_pend_reg       <= 1'b0;
			top_int_request_out <= 1'b0;
		end else begin
			highest_level_int_line_prev_reg <= highest_level_int_line_lvl;
			if (highest_level_int_line_lvl && !highest_level_int_line_prev_reg) begin
				highest_level_int_line_pend_reg <= 1'b1; // RULE4
			end else if (state_reg == IACKBT_END && is_interrupt_ack_cycle_reg
				&& level_reg == `IACKBT_TOP_LEVEL) begin
				highest_level_int_line_pend_reg <= 1'b0; // RULE4
			end
			top_int_request_out <= highest_level_int_line_pend_reg;
		end
	end
endmodule
`default_nettype wire

/* File: testbench/iackbt_props.sv */
`timescale 1ns/1ns
`default_nettype none
`include "iackbt_defs.svh"
// port-level watch on the acknowledge cycle outputs
module iackbt_props (
	input wire logic                    clock_in,
	input wire logic                    reset_in,
	input wire logic                    address_strobe_n_out,
	input wire logic                    data_strobe_pin_n_out,
	input wire logic                    cycle_done_out,
	input wire iackbt_pkg::iackbt_end_e end_kind_out,
	input wire logic [7:0]              vector_out,
	input wire logic                    spurious_exc_out,
	input wire logic                    fatal_fault_out
);
	import iackbt_pkg::*;
	default clocking cb @(posedge clock_in); endclocking
	default disable iff (reset_in);
	// strobe held and no end for three clocks after it falls
	sequence s_held3;
		(!address_strobe_n_out && !cycle_done_out) [*3];
	endsequence
	AST_MIN_LEN: assert property ($fell(address_strobe_n_out) |-> s_held3)
		else $error("cycle ended before three clocks");
	AST_STROBE_PAIR: assert property (!data_strobe_pin_n_out |-> !address_strobe_n_out)
		else $error("data strobe without address strobe");
	AST_DONE_PULSE: assert property (cycle_done_out |=> !cycle_done_out)
		else $error("done longer than one cycle");
	AST_DONE_END: assert property (cycle_done_out |-> ##[0:1] end_kind_out != IACKBT_END_NONE)
		else $error("done without end kind");
	AST_SPUR_KIND: assert property (spurious_exc_out |-> ##[0:2] end_kind_out == IACKBT_END_ERROR)
		else $error("spurious exception without error end");
	AST_SPUR_VEC: assert property (spurious_exc_out |-> ##[0:2] vector_out == `IACKBT_SPURIOUS_VECTOR)
		else $error("spurious exception with wrong vector");
	AST_FATAL_STICKY: assert property (fatal_fault_out |=> fatal_fault_out)
		else $error("fatal fault dropped");
	AST_RESET: assert property (disable iff (1'b0)
		reset_in |=> address_strobe_n_out && !cycle_done_out && !fatal_fault_out)
		else $error("outputs not cleared by reset");
endmodule
bind iackbt_top iackbt_props u_props (.clock_in(clock_in), .reset_in(reset_in),
	.address_strobe_n_out(address_strobe_n_out), .data_strobe_pin_n_out(data_strobe_pin_n_out),
	.cycle_done_out(cycle_done_out), .end_kind_out(end_kind_out), .vector_out(vector_out),
	.spurious_exc_out(spurious_exc_out), .fatal_fault_out(fatal_fault_out));
`default_nettype wire

/* File: testbench/iackbt_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// outside acknowledge logic; mode bits: 0 size ack, 1 autovector, 2 bus error
module iackbt_partner (
	input  wire logic       clock_in,
	input  wire logic       address_strobe_n_in,
	input  wire logic [2:0] mode_in,
	input  wire logic [3:0] waits_in,
	output wire logic       data_size_ack_n_out,
	output wire logic       autovector_request_n_out,
	output wire logic       bus_error_input_n_out
);
	int         n   = 0;
	logic [2:0] ans = 3'h0;
	// answer with the mode_in bits after the wait states, let go on strobe rise
	always @(posedge clock_in) begin
		n <= address_strobe_n_in ? 0 : n + 1;
		ans <= #1 (!address_strobe_n_in && n >= waits_in) ? mode_in : 3'h0;
	end
	assign data_size_ack_n_out      = !ans[0];
	assign autovector_request_n_out = !ans[1];
	assign bus_error_input_n_out    = !ans[2];
endmodule
`default_nettype wire

/* File: testbench/interrupt_ack_cycle_bus_cycle_termination_bench.sv */
`timescale 1ns/1ns
`default_nettype none
`include "iackbt_defs.svh"
module interrupt_ack_cycle_bus_cycle_termination_bench;
	import iackbt_pkg::*;
	logic        clock_in = 1'b0;
	logic        reset_in = 1'b1;
	logic        start    = 1'b0;
	logic        is_interrupt_ack_cycle  = 1'b1;
	logic        hl_n     = 1'b1;
	logic        saw_spur = 1'b0;
	logic [2:0]  level    = 3'h1;
	logic [2:0]  mode     = 3'h1;
	logic [3:0]  waits    = 4'h2;
	logic [7:0]  data     = 8'h00;
	logic        dack_n, autovector_request_n, bus_error_input_n, as_n, ds_n, interrupt_ack_cycle, done, vvalid, spur, fatal, top_req;
	logic [7:0]  vec;
	iackbt_end_e kind;
	int          bad_count = 0;
	int          checks    = 0;
	logic [2:0]  modes [4] = '{3'h1, 3'h2, 3'h3, 3'h6};
	always #5 clock_in = ~clock_in;
	// catch the one-cycle spurious pulse wherever it lands
	always @(posedge clock_in) if (spur === 1'b1) saw_spur <= 1'b1;
	iackbt_top u_dut (.clock_in(clock_in), .reset_in(reset_in), .cycle_start_in(start),
		.cycle_is_interrupt_ack_cycle_in(is_interrupt_ack_cycle), .interrupt_ack_cycle_level_in(level), .data_size_ack_n_in(dack_n),
		.autovector_request_n_in(autovector_request_n), .bus_error_input_n_in(bus_error_input_n),
		.highest_level_int_line_n_in(hl_n), .data_bus_in(data), .address_strobe_n_out(as_n),
		.data_strobe_pin_n_out(ds_n), .interrupt_ack_cycle_out(interrupt_ack_cycle), .cycle_done_out(done),
		.end_kind_out(kind), .vector_out(vec), .vector_valid_out(vvalid),
		.spurious_exc_out(spur), .fatal_fault_out(fatal), .top_int_request_out(top_req));
	iackbt_partner u_far (.clock_in(clock_in), .address_strobe_n_in(as_n), .mode_in(mode),
		.waits_in(waits), .data_size_ack_n_out(dack_n), .autovector_request_n_out(autovector_request_n),
		.bus_error_input_n_out(bus_error_input_n));
	// reference: size ack wins, error gives spurious, else vector from level
	function automatic logic [9:0] model(input logic [2:0] m, input logic [2:0] lv,
		input logic [7:0] d);
		if (m[0]) return {IACKBT_END_DATA, d};
		if (m[2]) return {IACKBT_END_ERROR, `IACKBT_SPURIOUS_VECTOR};
		return {IACKBT_END_AUTOVEC, `IACKBT_AUTOVEC_BASE + {5'h00, lv}};
	endfunction
	task automatic check(input logic [7:0] seen, input logic [7:0] want);
		checks++;
		if (seen !== want) begin
			bad_count++;
			$display("BAD t=%0t seen=%h want=%h", $time, seen, want);
		end
	endtask
	task automatic wrap_up;
		$display("checks=%0d bad_count=%0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	// one bus cycle, bounded wait for the end, drain the answers, compare
	task automatic run(input logic [2:0] m, input logic ack, input logic [2:0] lv);
		logic [9:0] e;
		int         k;
		@(posedge clock_in);
		#1;
		mode = m;
		is_interrupt_ack_cycle = ack;
		level = lv;
		data = 8'($urandom);
		waits = 4'(2 + $urandom % 4);
		saw_spur = 1'b0;
		start = 1'b1;
		@(posedge clock_in);
		#1;
		start = 1'b0;
		for (k = 0; k < 80 && done !== 1'b1; k++) begin
			@(posedge clock_in);
			#1;
		end
		e = model(m, lv, data);
		check(8'(k < 80), 8'h01);
		check(8'(vvalid), 8'(ack));
		check(8'(interrupt_ack_cycle), 8'(ack));
		check(8'(ds_n), 8'h01);
		repeat (10) @(posedge clock_in);
		#1;
		check(8'(kind), 8'(e[9:8]));
		if (ack) check(vec, e[7:0]);
		check(8'(saw_spur), 8'(m[2]));
		check(8'(fatal), 8'h00);
	endtask
	initial begin
		void'($urandom(13705));
		repeat (20) @(posedge clock_in);
		#1;
		reset_in = 1'b0;
		repeat (4) @(posedge clock_in);
		for (int i = 0; i < 12; i++) run(modes[i % 4], 1'b1, 3'(1 + $urandom % 7));
		run(3'h1, 1'b0, 3'h1);
		// top line asserted, dropped before the acknowledge, then asserted again
		hl_n = 1'b0;
		repeat (8) @(posedge clock_in);
		#1;
		check(8'(top_req), 8'h01);
		hl_n = 1'b1;
		repeat (3) @(posedge clock_in);
		#1;
		hl_n = 1'b0;
		run(3'h2, 1'b1, `IACKBT_TOP_LEVEL);
		check(8'(top_req), 8'h00);
		wrap_up();
	end
	// hang guard, far beyond the few hundred cycles the run needs
	initial begin
		#100000;
		bad_count++;
		wrap_up();
	end
endmodule
`default_nettype wire
